// >>> core_pll_defs.svh
// Constants for the core, network and memory PLL control logic.
`ifndef CORE_PLL_DEFS_SVH
`define CORE_PLL_DEFS_SVH

`define NUM_PLL 3
`define CH_CORE 0
`define CH_NET 1
`define CH_MEM 2

`define MULT_W 6
`define MULT_X10 6'h0A
`define MULT_X20 6'h14
`define MULT_RST 6'h0A

`define MASTER_W 4
`define MASTER_HOST 4'h6
`define MASTER_LINK 4'h7
`define MASTER_LAST 4'h7

`define CNT_W 11
`define RST_HOLD_CYC 256
`define LOCK_WAIT_CYC 2000
`define RST_HOLD_LAST 11'h0FF
`define LOCK_LAST 11'h7CF

`define SEL_RST 1'b0
`define PLL_RESET_BIT_RST 1'b0

`endif

// >>> core_pll_pkg.sv
// Types shared by the PLL control logic.
package core_pll_pkg;

  typedef enum logic [1:0] {
    LK_HELD,
    LK_LOCKING,
    LK_LOCKED
  } lock_state_t;

endpackage

// >>> pll_lock_seq.sv
// Reset hold, lock wait and output selection for one PLL.
`timescale 1ns/1ps
`include "core_pll_defs.svh"

module pll_lock_seq
  import core_pll_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic pll_rst_i,
  input wire logic out_sel_i,
  output logic locked_o,
  output logic use_pll_o,
  output logic hold_ok_o,
  output logic early_rel_o
);

  lock_state_t state_ff;
  logic [`CNT_W-1:0] cnt_ff;
  logic hold_met;

  assign hold_met = (cnt_ff >= `RST_HOLD_LAST);

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      state_ff <= LK_LOCKING;
    else
    begin
      unique case (state_ff)
        LK_HELD:
          if (!pll_rst_i)
            state_ff <= LK_LOCKING;
        LK_LOCKING:
          if (pll_rst_i)
            state_ff <= LK_HELD;
          else if (cnt_ff == `LOCK_LAST)
            state_ff <= LK_LOCKED; // see [R11]
        LK_LOCKED:
          if (pll_rst_i)
            state_ff <= LK_HELD; // see [R13]
      endcase
    end
  end

  // Counts cycles held in reset (saturating) or cycles since release.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      cnt_ff <= '0;
    else if (pll_rst_i && state_ff != LK_HELD)
      cnt_ff <= '0;
    else if (state_ff == LK_HELD && !pll_rst_i)
      cnt_ff <= '0;
    else if (state_ff == LK_HELD && !hold_met)
      cnt_ff <= cnt_ff + 11'h001; // see [R09]
    else if (state_ff == LK_LOCKING)
      cnt_ff <= cnt_ff + 11'h001;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      locked_o <= 1'b0;
    else
      locked_o <= !pll_rst_i && (state_ff == LK_LOCKED ||
        (state_ff == LK_LOCKING && cnt_ff == `LOCK_LAST));
  end

  // The PLL output is chosen only once it has locked, so the switch
  // from the bypassed reference never sees an unlocked output.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      use_pll_o <= 1'b0; // see [R16]
    else
      use_pll_o <= out_sel_i && !pll_rst_i &&
        state_ff == LK_LOCKED; // see [R17] see [R12]
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      hold_ok_o <= 1'b0;
    else
      hold_ok_o <= (state_ff == LK_HELD) && hold_met;
  end

  // Sticky marker of a reset released before the hold time was met.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      early_rel_o <= 1'b0;
    else if (state_ff == LK_HELD && !pll_rst_i && !hold_met)
      early_rel_o <= 1'b1; // see [R09]
  end

  a_lock_count: assert property ( // see [R11]
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(locked_o) |-> $past(cnt_ff) == `LOCK_LAST)
    else $error("lock reported after wrong wait");

  a_no_early_lock: assert property ( // see [R11]
    @(posedge clk_i) disable iff (sys_rst_i)
    (state_ff == LK_LOCKING && cnt_ff < `LOCK_LAST) |=> !locked_o)
    else $error("lock reported too early");

  a_early_flag: assert property ( // see [R09]
    @(posedge clk_i) disable iff (sys_rst_i)
    (state_ff == LK_HELD && !pll_rst_i && cnt_ff < `RST_HOLD_LAST)
    |=> early_rel_o)
    else $error("short reset hold not flagged");

  a_use_needs_lock: assert property ( // see [R17]
    @(posedge clk_i) disable iff (sys_rst_i)
    $rose(use_pll_o) |-> $past(state_ff) == LK_LOCKED && $past(out_sel_i))
    else $error("pll output chosen while not locked");

endmodule // pll_lock_seq

// >>> core_pll_reprogram_seq.sv
// Control of the core, network and memory PLLs and the core multiplier.
// Overview of operation
// [R01] Core clock comes from core PLL referenced by core_ref_clock.
// [R02] Multiplier never comes from straps; only multiplier_field writes change it.
// [R03] Writes accepted from all six cores, host port and serial link.
// [R04] Host reprograms only in host boot; one core owns run-time reprogramming.
// [R05] Software keeps core clock within the 500, 625 or 700 MHz grade.
// [R06] ROM boot offers only multipliers ten and twenty.
// [R07] First write: pll_output_select 0 and pll_reset_bit 1 together.
// [R08] Write the desired multiplier while the PLL is held in reset.
// [R09] Hold PLL reset at least 256 reference cycles.
// [R10] Then clear pll_reset_bit while still in bypass.
// [R11] Wait 2000 reference cycles for lock after releasing reset.
// [R12] Finally set pll_output_select to 1 to use the PLL output.
// [R13] Only core PLL multiplier programmable; others use same restart sequence.
// [R14] Network PLL uses second reference, memory PLL the third.
// [R15] At multiplier 32, reference at least 19.531 or 21.875 MHz.
// [R16] After reset the core PLL is disabled with the core clock bypassed; here pll_reset_bit resets to 0, so each PLL starts locking at once.
// [R17] Bypass passes the reference and switching selection stays glitch-free.
// [R18] Multiplier writes reach the PLL only through the reset sequence.
`timescale 1ns/1ps
`include "core_pll_defs.svh"

module core_pll_reprogram_seq
  import core_pll_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [`MASTER_W-1:0] wr_master_i,
  input wire logic [`NUM_PLL-1:0] ctl_wr_i,
  input wire logic [`NUM_PLL-1:0] ctl_sel_i,
  input wire logic [`NUM_PLL-1:0] ctl_rst_i,
  input wire logic mult_wr_i,
  input wire logic [`MULT_W-1:0] mult_val_i,
  input wire logic boot_mult_wr_i,
  input wire logic boot_mult_x20_i,
  output logic [`NUM_PLL-1:0] pll_output_select_o,
  output logic [`NUM_PLL-1:0] pll_reset_bit_o,
  output logic [`MULT_W-1:0] multiplier_field_o,
  output logic [`MULT_W-1:0] core_mult_o,
  output logic [`NUM_PLL-1:0] pll_locked_o,
  output logic [`NUM_PLL-1:0] pll_in_use_o,
  output logic [`NUM_PLL-1:0] hold_done_o,
  output logic [`NUM_PLL-1:0] early_release_o
);

  logic wr_ok;
  logic [`NUM_PLL-1:0] sel_ff;
  logic [`NUM_PLL-1:0] rst_ff;
  logic [`MULT_W-1:0] mult_field_ff;
  logic [`MULT_W-1:0] mult_act_ff;
  logic [`MULT_W-1:0] nxt_mult_field;

  // Every interconnect master that can issue memory writes may program
  // the PLLs: cores 0 to 5, the host parallel port and the serial link.
  assign wr_ok = (wr_master_i <= `MASTER_LAST); // see [R03]

  // Channel 0 is the core PLL on core_ref_clock (clk_i), channel 1 the
  // network PLL and channel 2 the memory PLL; all share the control
  // bits and the restart sequencer, only channel 0 has a multiplier.
  genvar ch;
  generate
    for (ch = 0; ch < `NUM_PLL; ch = ch + 1)
    begin : g_pll
      always_ff @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
          sel_ff[ch] <= `SEL_RST; // see [R16]
        else if (ctl_wr_i[ch] && wr_ok)
          sel_ff[ch] <= ctl_sel_i[ch]; // see [R07] see [R12]
      end

      always_ff @(posedge clk_i or posedge sys_rst_i)
      begin
        if (sys_rst_i)
          rst_ff[ch] <= `PLL_RESET_BIT_RST;
        else if (ctl_wr_i[ch] && wr_ok)
          rst_ff[ch] <= ctl_rst_i[ch]; // see [R07] see [R10]
      end

      pll_lock_seq u_seq (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .pll_rst_i(rst_ff[ch]),
        .out_sel_i(sel_ff[ch]),
        .locked_o(pll_locked_o[ch]),
        .use_pll_o(pll_in_use_o[ch]), // see [R01] see [R14] see [R13]
        .hold_ok_o(hold_done_o[ch]),
        .early_rel_o(early_release_o[ch])
      );
    end
  endgenerate

  // A direct write wins over a boot preset in the same cycle; the boot
  // path can only load the two ROM defaults.
  always_comb
  begin
    nxt_mult_field = mult_field_ff;
    if (mult_wr_i && wr_ok)
      nxt_mult_field = mult_val_i; // see [R02] see [R08]
    else if (boot_mult_wr_i && wr_ok)
      nxt_mult_field = boot_mult_x20_i ? `MULT_X20 : `MULT_X10; // see [R06]
  end

  // The reset value is a fixed constant; no strap pin is sampled.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mult_field_ff <= `MULT_RST; // see [R02]
    else
      mult_field_ff <= nxt_mult_field;
  end

  // The PLL only sees the written value while it is held in reset, so a
  // write to a locked, enabled PLL cannot disturb the running clock.
  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      mult_act_ff <= `MULT_RST;
    else if (rst_ff[`CH_CORE])
      mult_act_ff <= mult_field_ff; // see [R18]
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pll_output_select_o <= '0;
    else
      pll_output_select_o <= (ctl_wr_i & {`NUM_PLL{wr_ok}} & ctl_sel_i) |
        (~(ctl_wr_i & {`NUM_PLL{wr_ok}}) & sel_ff);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      pll_reset_bit_o <= '0;
    else
      pll_reset_bit_o <= (ctl_wr_i & {`NUM_PLL{wr_ok}} & ctl_rst_i) |
        (~(ctl_wr_i & {`NUM_PLL{wr_ok}}) & rst_ff);
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      multiplier_field_o <= `MULT_RST;
    else
      multiplier_field_o <= nxt_mult_field;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      core_mult_o <= `MULT_RST;
    else if (rst_ff[`CH_CORE])
      core_mult_o <= mult_field_ff; // see [R18]
  end

  sequence s_enter_reset;
    ctl_wr_i[`CH_CORE] && wr_ok && ctl_rst_i[`CH_CORE] &&
      !ctl_sel_i[`CH_CORE];
  endsequence

  sequence s_bypass_held;
    rst_ff[`CH_CORE] && !sel_ff[`CH_CORE];
  endsequence

  a_enter_bypass: assert property ( // see [R07]
    @(posedge clk_i) disable iff (sys_rst_i)
    s_enter_reset |=> s_bypass_held ##1 !pll_in_use_o[`CH_CORE])
    else $error("bypass and reset not taken together");

  a_bypass_clock: assert property ( // see [R17]
    @(posedge clk_i) disable iff (sys_rst_i)
    !sel_ff[`CH_CORE] |=> !pll_in_use_o[`CH_CORE])
    else $error("pll output used while bypass selected");

  a_mult_frozen: assert property ( // see [R18]
    @(posedge clk_i) disable iff (sys_rst_i)
    !rst_ff[`CH_CORE] |=> $stable(mult_act_ff))
    else $error("active multiplier moved outside reset");

  a_mult_load: assert property ( // see [R08]
    @(posedge clk_i) disable iff (sys_rst_i)
    rst_ff[`CH_CORE] |=> mult_act_ff == $past(mult_field_ff))
    else $error("multiplier not passed during reset");

  a_write_taken: assert property ( // see [R03]
    @(posedge clk_i) disable iff (sys_rst_i)
    (mult_wr_i && wr_master_i == `MASTER_HOST) |=>
      mult_field_ff == $past(mult_val_i))
    else $error("host multiplier write lost");

  a_boot_preset: assert property ( // see [R06]
    @(posedge clk_i) disable iff (sys_rst_i)
    (boot_mult_wr_i && !mult_wr_i && wr_ok) |=>
      (mult_field_ff == `MULT_X10 || mult_field_ff == `MULT_X20))
    else $error("boot preset outside the two defaults");

  a_ctl_follow: assert property ( // see [R10]
    @(posedge clk_i) disable iff (sys_rst_i)
    (ctl_wr_i[`CH_CORE] && wr_master_i == `MASTER_LINK) |=>
      rst_ff[`CH_CORE] == $past(ctl_rst_i[`CH_CORE]))
    else $error("control write not taken");

  a_reset_drops_use: assert property ( // see [R13]
    @(posedge clk_i) disable iff (sys_rst_i)
    rst_ff[`CH_NET] |=> !pll_in_use_o[`CH_NET] ##1 !pll_locked_o[`CH_NET])
    else $error("network pll used while in reset");

endmodule // core_pll_reprogram_seq

// >>> tb_top.sv
// Self-checking testbench for the PLL control and multiplier sequencer.
`timescale 1ns/1ps
`include "core_pll_defs.svh"

module tb_top
  import core_pll_pkg::*;
;
  logic clk_i;
  logic sys_rst_i;
  logic [`MASTER_W-1:0] wr_master_i;
  logic [`NUM_PLL-1:0] ctl_wr_i;
  logic [`NUM_PLL-1:0] ctl_sel_i;
  logic [`NUM_PLL-1:0] ctl_rst_i;
  logic mult_wr_i;
  logic [`MULT_W-1:0] mult_val_i;
  logic boot_mult_wr_i;
  logic boot_mult_x20_i;
  logic [`NUM_PLL-1:0] sel_o;
  logic [`NUM_PLL-1:0] rst_o;
  logic [`MULT_W-1:0] field_o;
  logic [`MULT_W-1:0] core_mult_o;
  logic [`NUM_PLL-1:0] locked_o;
  logic [`NUM_PLL-1:0] in_use_o;
  logic [`NUM_PLL-1:0] hold_o;
  logic [`NUM_PLL-1:0] early_o;
  int miscompares;
  int checks;

  core_pll_reprogram_seq dut (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .wr_master_i(wr_master_i),
    .ctl_wr_i(ctl_wr_i),
    .ctl_sel_i(ctl_sel_i),
    .ctl_rst_i(ctl_rst_i),
    .mult_wr_i(mult_wr_i),
    .mult_val_i(mult_val_i),
    .boot_mult_wr_i(boot_mult_wr_i),
    .boot_mult_x20_i(boot_mult_x20_i),
    .pll_output_select_o(sel_o),
    .pll_reset_bit_o(rst_o),
    .multiplier_field_o(field_o),
    .core_mult_o(core_mult_o),
    .pll_locked_o(locked_o),
    .pll_in_use_o(in_use_o),
    .hold_done_o(hold_o),
    .early_release_o(early_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok)
    begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Entered at a falling edge; the write is taken at the next rising edge.
  task automatic ctl_write(input int ch, input logic sel, input logic rst,
                           input logic [`MASTER_W-1:0] m);
    wr_master_i = m;
    ctl_sel_i = {`NUM_PLL{sel}};
    ctl_rst_i = {`NUM_PLL{rst}};
    ctl_wr_i = 3'h1 << ch;
    @(negedge clk_i);
    ctl_wr_i = 3'h0;
  endtask

  task automatic mult_write(input logic [`MULT_W-1:0] v,
                            input logic [`MASTER_W-1:0] m,
                            input logic boot, input logic x20);
    wr_master_i = m;
    mult_val_i = v;
    boot_mult_x20_i = x20;
    mult_wr_i = ~boot;
    boot_mult_wr_i = boot;
    @(negedge clk_i);
    mult_wr_i = 1'b0;
    boot_mult_wr_i = 1'b0;
  endtask

  // Finishes the restart: release after 256 held cycles, lock, enable.
  task automatic relock(input int ch, input int done);
    int i;
    wait_n(255 - done);
    ctl_write(ch, 1'b0, 1'b0, 4'h0);
    chk(rst_o[ch] === 1'b0 && sel_o[ch] === 1'b0, "release");
    wait_n(1990);
    chk(early_o[ch] === 1'b0, "early flag on full hold");
    chk(locked_o[ch] === 1'b0, "locked too soon");
    i = 0;
    while (locked_o[ch] !== 1'b1 && i < 40)
    begin
      wait_n(1);
      i++;
    end
    if (locked_o[ch] !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] %0t lock timeout", $time);
      complete_run();
    end
    chk(in_use_o[ch] === 1'b0, "pll used before enable");
    ctl_write(ch, 1'b1, 1'b0, 4'h0);
    chk(in_use_o[ch] === 1'b0, "switch too early");
    wait_n(2);
    chk(in_use_o[ch] === 1'b1, "pll output not taken");
  endtask

  task automatic t_reset();
    chk(sel_o === 3'h0 && rst_o === 3'h0, "reset bits");
    chk(field_o === `MULT_RST, "reset field");
    chk(core_mult_o === `MULT_RST, "reset mult");
    wait_n(2010);
    chk(locked_o === 3'h7, "no lock after reset");
    chk(in_use_o === 3'h0, "bypass after reset");
    $display("test reset done");
  endtask

  task automatic t_core();
    ctl_write(0, 1'b0, 1'b1, 4'h0);
    chk(sel_o[0] === 1'b0 && rst_o[0] === 1'b1, "enter bypass");
    // Multiplier 12 on the 50 MHz reference gives a 600 MHz core clock.
    mult_write(6'h0C, 4'h0, 1'b0, 1'b0);
    chk(field_o === 6'h0C, "mult field");
    wait_n(1);
    chk(core_mult_o === 6'h0C, "mult not applied in reset");
    relock(0, 2);
    chk(int'(core_mult_o) * 50 <= 700, "core clock above grade");
    mult_write(6'h0E, 4'h0, 1'b0, 1'b0);
    wait_n(3);
    chk(field_o === 6'h0E, "late write lost");
    chk(core_mult_o === 6'h0C, "mult leak");
    chk(in_use_o[0] === 1'b1, "core output lost");
    $display("test core done");
  endtask

  task automatic t_master();
    for (int m = 0; m < 8; m++)
    begin
      mult_write(6'h18 + 6'(m), 4'(m), 1'b0, 1'b0);
      chk(field_o === 6'h18 + 6'(m), "master write lost");
      wait_n(1);
    end
    mult_write(6'h11, 4'h8, 1'b0, 1'b0);
    ctl_write(1, 1'b0, 1'b1, 4'h8);
    wait_n(1);
    chk(field_o === 6'h1F, "bad master field");
    chk(rst_o[1] === 1'b0, "bad master control");
    ctl_write(1, 1'b0, 1'b1, 4'h7);
    chk(rst_o[1] === 1'b1 && field_o === 6'h1F, "link write");
    relock(1, 0);
    chk(in_use_o === 3'h3 && rst_o[2] === 1'b0, "channel mixup");
    $display("test master done");
  endtask

  task automatic t_boot();
    mult_write(6'h00, 4'h0, 1'b1, 1'b1);
    chk(field_o === `MULT_X20, "boot x20");
    wait_n(1);
    mult_write(6'h00, 4'h2, 1'b1, 1'b0);
    chk(field_o === `MULT_X10, "boot x10");
    wait_n(2);
    chk(core_mult_o === 6'h0C, "boot preset leak");
    $display("test boot done");
  endtask

  task automatic t_early();
    ctl_write(2, 1'b0, 1'b1, 4'h0);
    wait_n(10);
    chk(hold_o[2] === 1'b0 && early_o[2] === 1'b0, "short hold");
    ctl_write(2, 1'b0, 1'b0, 4'h0);
    wait_n(1);
    chk(early_o[2] === 1'b1, "early release missed");
    ctl_write(2, 1'b0, 1'b1, 4'h0);
    wait_n(300);
    chk(hold_o[2] === 1'b1 && early_o[2] === 1'b1, "hold flags");
    sys_rst_i = 1'b1;
    wait_n(2);
    sys_rst_i = 1'b0;
    wait_n(1);
    chk(early_o === 3'h0 && field_o === 6'h0A, "second reset");
    chk(in_use_o === 3'h0 && sel_o === 3'h0, "bypass again");
    $display("test early done");
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    wr_master_i = 4'h0;
    ctl_wr_i = 3'h0;
    ctl_sel_i = 3'h0;
    ctl_rst_i = 3'h0;
    mult_wr_i = 1'b0;
    mult_val_i = 6'h00;
    boot_mult_wr_i = 1'b0;
    boot_mult_x20_i = 1'b0;
    miscompares = 0;
    checks = 0;
    wait_n(12);
    sys_rst_i = 1'b0;
    t_reset();
    t_core();
    t_master();
    t_boot();
    t_early();
    complete_run();
  end
endmodule // tb_top
